// ### bench/crrd_chk_sva.sv
// port assertions for the call, interrupt return and software reset decoder
`include "crrd_regs.vh"
module crrd_chk
(
	input logic                    clk,
	input logic                    rstn,
	input logic [`CRRD_OP_W-1:0]   instr_word,
	input logic [`CRRD_PC_W-1:0]   return_stack_top,
	input logic [`CRRD_PC_W-1:0]   pc_q,
	input logic                    stack_push_q,
	input logic [`CRRD_PC_W-1:0]   stack_push_data_q,
	input logic                    stack_pop_q,
	input logic                    fetch_discard_q,
	input logic                    ctx_restore_q,
	input logic [`CRRD_CTX_W-1:0]  ctx_out_q,
	input logic                    gie_high_q,
	input logic                    gie_low_q,
	input logic [`CRRD_STAT_W-1:0] int_state_q,
	input logic                    sw_reset_q
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	// word history so each pulse can be tied to the word decoded at its Q1
	logic [`CRRD_OP_W-1:0] ins_q [5];
	always @(posedge clk)
	begin
		ins_q[0] <= instr_word;
		for (int i = 1; i < 5; i++)
			ins_q[i] <= ins_q[i-1];
	end
	// only pushes caused by a call qualify
	sequence s_call;
		stack_push_q && ins_q[1][15:11] == `CRRD_RELATIVE_CALL_OP_PFX;
	endsequence
	sequence s_ret;
		stack_pop_q && ins_q[3][15:1] == `CRRD_RETI_PFX;
	endsequence
	property p_call_tgt;
		logic [`CRRD_PC_W-1:0] t;
		(s_call, t = stack_push_data_q + {{9{ins_q[1][10]}}, ins_q[1][10:0], 1'b0})
			|-> ##2 pc_q == t;
	endproperty
	a_call_target: assert property (p_call_tgt)
		else $error("call target wrong");
	a_call_push: assert property (s_call |-> stack_push_data_q == pc_q ##1 !stack_push_q)
		else $error("call push wrong");
	a_ret_pc: assert property (s_ret |-> pc_q == $past(return_stack_top) && fetch_discard_q)
		else $error("return pc wrong");
	a_ret_select: assert property (s_ret |-> ctx_restore_q == ins_q[3][0])
		else $error("restore select wrong");
	a_ctx_hold: assert property (!ctx_restore_q && !$past(sw_reset_q) |-> $stable(ctx_out_q))
		else $error("context changed");
	a_ret_nested: assert property (s_ret and ($past(int_state_q) == `CRRD_STAT_HIGH_LOW)
		|-> int_state_q == `CRRD_STAT_LOW && gie_high_q)
		else $error("nested exit wrong");
	a_ret_low: assert property (s_ret and ($past(int_state_q) == `CRRD_STAT_LOW)
		|-> int_state_q == `CRRD_STAT_MAIN && gie_low_q)
		else $error("low exit wrong");
	a_rst_when: assert property (sw_reset_q |-> ins_q[1] == `CRRD_SWRST_OP)
		else $error("reset phase wrong");
	a_rst_clear: assert property (sw_reset_q |=> !sw_reset_q && pc_q == 21'h0
		&& int_state_q == 2'h0 && !gie_high_q && !gie_low_q)
		else $error("reset left state");
endmodule
bind crrd_top crrd_chk chk (.*);

// ### bench/tb_top.sv
// self-checking bench for the call, interrupt return and software reset decoder
`include "crrd_regs.vh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [103:0] ctx_a = {13{8'h3c}};
	localparam logic [103:0] ctx_b = {13{8'h5a}};
	localparam logic [103:0] ctx_c = 104'h0102030405060708090a0b0c0d;
	logic                   clk;
	logic                   rstn;
	logic [`CRRD_OP_W-1:0]  instr_word;
	logic [`CRRD_PC_W-1:0]  return_stack_top;
	logic                   irq_enter;
	logic                   irq_high;
	logic [`CRRD_CTX_W-1:0] ctx_live;
	logic [`CRRD_PC_W-1:0]  pc_q;
	logic                   stack_push_q;
	logic [`CRRD_PC_W-1:0]  stack_push_data_q;
	logic                   stack_pop_q;
	logic                   fetch_discard_q;
	logic                   ctx_restore_q;
	logic [`CRRD_CTX_W-1:0] ctx_out_q;
	logic                   gie_high_q;
	logic                   gie_low_q;
	logic [1:0]             int_state_q;
	logic                   irq_taken_q;
	logic                   sw_reset_q;
	int                     bad_count = 0;
	int                     cmp_count = 0;
	int                     cycles = 0;
	crrd_top dut (.*);
	task automatic ck(input logic ok, input string m);
		cmp_count++;
		if (ok !== 1'b1)
		begin
			bad_count++;
			$display("Error %0t %s", $time, m);
		end
	endtask
	task automatic st(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic summarize;
		if (bad_count == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// most negative offset, so the target wraps below the call
	task automatic t_call;
		logic [20:0] p;
		p = pc_q;
		instr_word = {`CRRD_RELATIVE_CALL_OP_PFX, 11'h400};
		st(1);
		instr_word = 16'h0000;
		st(1);
		ck(stack_push_q === 1'b1 && stack_push_data_q === p, "call push");
		st(2);
		ck(pc_q === p - 21'h000800, "call target");
		ck(fetch_discard_q === 1'b1, "call discard");
		st(4);
	endtask
	task automatic t_enter(input logic h, input logic [103:0] v, input logic [1:0] s);
		logic seen;
		seen = 1'b0;
		irq_enter = 1'b1;
		irq_high = h;
		ctx_live = v;
		repeat (8)
		begin
			st(1);
			seen |= irq_taken_q;
			irq_enter = 1'b0;
		end
		ck(seen === 1'b1 && int_state_q === s, "irq entry");
		ctx_live = ~v;
	endtask
	task automatic t_ret(input logic s, input logic [103:0] v, input logic [1:0] e,
		input logic h, input logic l);
		logic [103:0] old;
		old = ctx_out_q;
		return_stack_top = return_stack_top + 21'h000124;
		instr_word = {`CRRD_RETI_PFX, s};
		st(1);
		instr_word = 16'h0000;
		st(3);
		ck(pc_q === return_stack_top && stack_pop_q === 1'b1, "ret pc");
		ck(fetch_discard_q === 1'b1, "ret discard");
		ck(ctx_restore_q === s && ctx_out_q === (s ? v : old), "ret context");
		ck(int_state_q === e, "ret state");
		ck(gie_high_q === h && gie_low_q === l, "ret enables");
		st(4);
	endtask
	task automatic t_reset;
		instr_word = `CRRD_SWRST_OP;
		st(1);
		instr_word = 16'h0000;
		st(1);
		ck(sw_reset_q === 1'b1, "reset start");
		st(1);
		ck(sw_reset_q === 1'b0 && pc_q === 21'h0 && int_state_q === 2'h0, "reset pc");
		ck(gie_high_q === 1'b0 && gie_low_q === 1'b0 && ctx_out_q === 104'h0, "reset regs");
	endtask
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			bad_count++;
			summarize();
		end
	end
	initial
	begin
		rstn = 1'b0;
		instr_word = 16'h0000;
		return_stack_top = 21'h000400;
		irq_enter = 1'b0;
		irq_high = 1'b0;
		ctx_live = 104'h0;
		st(20);
		rstn = 1'b1;
		st(8);
		t_call;
		t_enter(1'b0, ctx_b, 2'h1);
		t_enter(1'b1, ctx_c, 2'h3);
		t_ret(1'b1, ctx_c, 2'h1, 1'b1, 1'b0);
		t_ret(1'b1, ctx_b, 2'h0, 1'b1, 1'b1);
		t_enter(1'b1, ctx_a, 2'h2);
		t_ret(1'b0, ctx_a, 2'h0, 1'b1, 1'b1);
		t_enter(1'b0, ctx_a, 2'h1);
		t_reset;
		t_call;
		summarize();
	end
endmodule

// ### rtl/crrd_qphase.v
// quarter phase generator: splits each instruction cycle into four clocks
`include "crrd_regs.vh"

module crrd_qphase
(
	input  wire       clk,
	input  wire       rstn,
	input  wire       restart,
	output reg  [3:0] q_q
);

	reg [3:0] q_d;

	always @*
	begin
		q_d = {q_q[2:0], q_q[3]};
		// a software reset restarts the sequence at the first quarter
		if (restart)
			q_d = `CRRD_Q1;
	end

	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			q_q <= `CRRD_Q_RST;
		else
			q_q <= q_d;
	end

endmodule

// ### rtl/crrd_regs.vh
// constants for the call, return-from-interrupt and software reset decoder
`ifndef CRRD_REGS_VH
`define CRRD_REGS_VH

// program counter and opcode widths
`define CRRD_PC_W           21
`define CRRD_OP_W           16

// relative call: prefix in the top five bits, 11-bit signed word offset below
`define CRRD_RELATIVE_CALL_OP_PFX      5'h1b
`define CRRD_RELATIVE_CALL_OP_OFS_W    11
`define CRRD_PC_STEP        21'h000002

// software reset opcode
`define CRRD_SWRST_OP       16'h00ff

// interrupt return: upper 15 bits fixed, bit 0 selects context restore
`define CRRD_RETI_PFX       15'h0008
`define CRRD_RETI_SEL_BIT   0

// context bus: thirteen bytes, byte index times eight is the low bit
`define CRRD_CTX_W          104
`define CRRD_CTX_WORKING    0
`define CRRD_CTX_STATUS     1
`define CRRD_CTX_BANK       2
`define CRRD_CTX_IP0_HIGH   3
`define CRRD_CTX_IP0_LOW    4
`define CRRD_CTX_IP1_HIGH   5
`define CRRD_CTX_IP1_LOW    6
`define CRRD_CTX_IP2_HIGH   7
`define CRRD_CTX_IP2_LOW    8
`define CRRD_CTX_PROD_HIGH  9
`define CRRD_CTX_PROD_LOW   10
`define CRRD_CTX_LATCH_HIGH 11
`define CRRD_CTX_LATCH_UPR  12

// shadow bank indices
`define CRRD_BANK_MAIN      1'b0
`define CRRD_BANK_LOW       1'b1

// interrupt state field of the interrupt control register
`define CRRD_STAT_W         2
`define CRRD_STAT_MAIN      2'h0
`define CRRD_STAT_LOW       2'h1
`define CRRD_STAT_HIGH      2'h2
`define CRRD_STAT_HIGH_LOW  2'h3

// quarter phases, one-hot
`define CRRD_Q1             4'h1
`define CRRD_Q_RST          4'h1

`endif

// ### rtl/crrd_top.v
// decode and execute of relative call, interrupt return and software reset
//
// Function
// - a relative call pushes its own address plus 2 in the second quarter, writes the PC in the fourth, then idles one cycle.
// - the relative call target is the incremented PC plus twice the 11-bit signed offset after prefix 11011.
// - the software reset opcode 0x00ff returns every register and flag to its master clear value in one single-cycle word.
// - the software reset decodes in the first quarter, starts the reset in the second, clears in the third and skips the fourth by restarting at the first.
// - the interrupt return 0x0010/0x0011 pops the return stack into the PC and takes two cycles.
// - with the select bit at 1 the interrupt return copies the shadow context into all thirteen context registers.
// - with the select bit at 0 the interrupt return leaves every context register untouched.
// - two shadow sets, main and low, exist and the return restores from the one matching the current CPU state.
// - the interrupt return sets the high or low global interrupt enable for the level being left.
// - the interrupt return updates the interrupt state bits to show the level has been left.
// - loading the popped address never changes the program counter latches except through the shadow restore.
`include "crrd_regs.vh"

module crrd_top
(
	input  wire                            clk,
	input  wire                            rstn,
	input  wire [`CRRD_OP_W-1:0]           instr_word,
	input  wire [`CRRD_PC_W-1:0]           return_stack_top,
	input  wire                            irq_enter,
	input  wire                            irq_high,
	input  wire [`CRRD_CTX_W-1:0]          ctx_live,
	output reg  [`CRRD_PC_W-1:0]           pc_q,
	output reg                             stack_push_q,
	output reg  [`CRRD_PC_W-1:0]           stack_push_data_q,
	output reg                             stack_pop_q,
	output reg                             fetch_discard_q,
	output reg                             ctx_restore_q,
	output reg  [`CRRD_CTX_W-1:0]          ctx_out_q,
	output reg                             gie_high_q,
	output reg                             gie_low_q,
	output reg  [`CRRD_STAT_W-1:0]         int_state_q,
	output reg                             irq_taken_q,
	output reg                             sw_reset_q
);

	// execution states, one-hot
	localparam [2:0] ST_EXEC = 3'h1;
	localparam [2:0] ST_WAIT = 3'h2;
	localparam [2:0] ST_RST  = 3'h4;

	// decoded operation held from the first quarter to the fourth
	localparam [3:0] OP_NONE  = 4'h1;
	localparam [3:0] OP_RELATIVE_CALL_OP = 4'h2;
	localparam [3:0] OP_RETI  = 4'h4;
	localparam [3:0] OP_SWRST = 4'h8;

	wire [3:0]             q_q;
	reg  [2:0]             state_q;
	reg  [2:0]             state_d;
	reg  [3:0]             op_q;
	reg  [3:0]             op_d;
	reg                    sel_q;
	reg  [`CRRD_RELATIVE_CALL_OP_OFS_W-1:0] ofs_q;
	reg  [`CRRD_PC_W-1:0]  pc_d;
	reg  [`CRRD_PC_W-1:0]  target;
	reg  [`CRRD_STAT_W-1:0] stat_d;
	reg                    gie_high_d;
	reg                    gie_low_d;
	reg                    bank_sel;
	reg                    save_main;
	reg                    save_low;
	reg  [`CRRD_CTX_W-1:0] shadow_q [0:1];
	wire                   q1;
	wire                   q2;
	wire                   q4;
	wire                   is_relative_call_op;
	wire                   is_swrst;
	wire                   is_reti;
	wire                   take_irq;

	crrd_qphase u_qphase
	(
		.clk     (clk),
		.rstn    (rstn),
		.restart (sw_reset_q),
		.q_q     (q_q)
	);

	assign q1 = q_q[0];
	assign q2 = q_q[1];
	assign q4 = q_q[3];

	assign is_relative_call_op = (instr_word[15:11] == `CRRD_RELATIVE_CALL_OP_PFX);
	assign is_swrst = (instr_word == `CRRD_SWRST_OP);
	assign is_reti  = (instr_word[15:1] == `CRRD_RETI_PFX);

	// interrupts are only taken at a first quarter with no control flow pending
	assign take_irq = q1 && irq_enter && (state_q == ST_EXEC) && (op_q == OP_NONE);

	// decode in the first quarter; the wait cycle ignores the prefetched word
	always @*
	begin
		op_d = op_q;
		if (q1)
		begin
			op_d = OP_NONE;
			if (state_q == ST_EXEC)
			begin
				if (is_relative_call_op)
					op_d = OP_RELATIVE_CALL_OP;
				else if (is_reti)
					op_d = OP_RETI;
				else if (is_swrst)
					op_d = OP_SWRST;
			end
		end
	end

	always @*
	begin
		state_d = state_q;
		case (state_q)
			ST_EXEC:
			begin
				if (q4 && (op_q == OP_RELATIVE_CALL_OP || op_q == OP_RETI))
					state_d = ST_WAIT;
				else if (q2 && op_q == OP_SWRST)
					state_d = ST_RST;
			end
			ST_WAIT:
			begin
				if (q4)
					state_d = ST_EXEC;
			end
			ST_RST:
				state_d = ST_EXEC;
			default:
				state_d = ST_EXEC;
		endcase
	end

	// program counter: relative target or popped top, else plain increment
	always @*
	begin
		target = pc_q + {{(`CRRD_PC_W-`CRRD_RELATIVE_CALL_OP_OFS_W-1){ofs_q[`CRRD_RELATIVE_CALL_OP_OFS_W-1]}},
			ofs_q, 1'b0};
		pc_d = pc_q;
		if (q4)
		begin
			if (state_q == ST_EXEC && op_q == OP_RELATIVE_CALL_OP)
				pc_d = target;
			else if (state_q == ST_EXEC && op_q == OP_RETI)
				pc_d = return_stack_top;
			else
				pc_d = pc_q + `CRRD_PC_STEP;
		end
	end

	// restore from the bank that matches the level currently running
	always @*
	begin
		if (int_state_q == `CRRD_STAT_LOW)
			bank_sel = `CRRD_BANK_LOW;
		else
			bank_sel = `CRRD_BANK_MAIN;
	end

	// leaving a level: state falls back, that level's enable comes back on
	always @*
	begin
		stat_d     = int_state_q;
		gie_high_d = gie_high_q;
		gie_low_d  = gie_low_q;
		if (q4 && state_q == ST_EXEC && op_q == OP_RETI)
		begin
			case (int_state_q)
				`CRRD_STAT_HIGH_LOW:
				begin
					stat_d     = `CRRD_STAT_LOW;
					gie_high_d = 1'b1;
				end
				`CRRD_STAT_HIGH:
				begin
					stat_d     = `CRRD_STAT_MAIN;
					gie_high_d = 1'b1;
				end
				`CRRD_STAT_LOW:
				begin
					stat_d    = `CRRD_STAT_MAIN;
					gie_low_d = 1'b1;
				end
				default:
					gie_high_d = 1'b1;
			endcase
		end
		else if (take_irq)
		begin
			if (irq_high)
			begin
				gie_high_d = 1'b0;
				if (int_state_q == `CRRD_STAT_LOW)
					stat_d = `CRRD_STAT_HIGH_LOW;
				else
					stat_d = `CRRD_STAT_HIGH;
			end
			else
			begin
				gie_low_d = 1'b0;
				stat_d    = `CRRD_STAT_LOW;
			end
		end
	end

	always @*
	begin
		save_main = take_irq && irq_high;
		save_low  = take_irq && !irq_high;
	end

	// two shadow sets: main captured on entry to the high level, low on entry to the low level
	genvar b;
	generate
		for (b = 0; b < 2; b = b + 1)
		begin : g_shadow
			always @(posedge clk or negedge rstn)
			begin
				if (!rstn)
					shadow_q[b] <= {`CRRD_CTX_W{1'b0}};
				else if (sw_reset_q)
					shadow_q[b] <= {`CRRD_CTX_W{1'b0}};
				else if ((b == `CRRD_BANK_MAIN) ? save_main : save_low)
					shadow_q[b] <= ctx_live;
			end
		end
	endgenerate

	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state_q           <= ST_EXEC;
			op_q              <= OP_NONE;
			sel_q             <= 1'b0;
			ofs_q             <= {`CRRD_RELATIVE_CALL_OP_OFS_W{1'b0}};
			pc_q              <= {`CRRD_PC_W{1'b0}};
			stack_push_q      <= 1'b0;
			stack_push_data_q <= {`CRRD_PC_W{1'b0}};
			stack_pop_q       <= 1'b0;
			fetch_discard_q   <= 1'b0;
			ctx_restore_q     <= 1'b0;
			ctx_out_q         <= {`CRRD_CTX_W{1'b0}};
			gie_high_q        <= 1'b0;
			gie_low_q         <= 1'b0;
			int_state_q       <= `CRRD_STAT_MAIN;
			irq_taken_q       <= 1'b0;
			sw_reset_q        <= 1'b0;
		end
		else if (sw_reset_q)
		begin
			// same values as a master clear, one clock after the start
			state_q           <= ST_EXEC;
			op_q              <= OP_NONE;
			sel_q             <= 1'b0;
			ofs_q             <= {`CRRD_RELATIVE_CALL_OP_OFS_W{1'b0}};
			pc_q              <= {`CRRD_PC_W{1'b0}};
			stack_push_q      <= 1'b0;
			stack_push_data_q <= {`CRRD_PC_W{1'b0}};
			stack_pop_q       <= 1'b0;
			fetch_discard_q   <= 1'b0;
			ctx_restore_q     <= 1'b0;
			ctx_out_q         <= {`CRRD_CTX_W{1'b0}};
			gie_high_q        <= 1'b0;
			gie_low_q         <= 1'b0;
			int_state_q       <= `CRRD_STAT_MAIN;
			irq_taken_q       <= 1'b0;
			sw_reset_q        <= 1'b0;
		end
		else
		begin
			state_q     <= state_d;
			op_q        <= op_d;
			pc_q        <= pc_d;
			int_state_q <= stat_d;
			gie_high_q  <= gie_high_d;
			gie_low_q   <= gie_low_d;
			irq_taken_q <= take_irq;
			if (q1)
			begin
				sel_q <= instr_word[`CRRD_RETI_SEL_BIT];
				ofs_q <= instr_word[`CRRD_RELATIVE_CALL_OP_OFS_W-1:0];
			end
			// return address is the incremented PC, pushed in the second quarter
			stack_push_q <= q2 && state_q == ST_EXEC && op_q == OP_RELATIVE_CALL_OP;
			if (q2 && state_q == ST_EXEC && op_q == OP_RELATIVE_CALL_OP)
				stack_push_data_q <= pc_q;
			// quarter three of the reset clears everything and restarts the phases at the first quarter
			sw_reset_q <= q2 && state_q == ST_EXEC && op_q == OP_SWRST;
			stack_pop_q <= q4 && state_q == ST_EXEC && op_q == OP_RETI;
			// the word fetched during the first cycle belongs to the old flow
			fetch_discard_q <= q4 && state_q == ST_EXEC &&
				(op_q == OP_RELATIVE_CALL_OP || op_q == OP_RETI);
			// select bit clear leaves context alone: no strobe, bus held
			ctx_restore_q <= q4 && state_q == ST_EXEC && op_q == OP_RETI && sel_q;
			if (q4 && state_q == ST_EXEC && op_q == OP_RETI && sel_q)
				ctx_out_q <= shadow_q[bank_sel];
		end
	end

endmodule
